// ==== logic/pdc_power_ctrl.v ====
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defs.vh"

// Function
// - Reference strap high picks external reference, low picks internal.
// - Sample/hold: a channel held low for the timeout powers down alone.
// - Reference powers down in external mode or with all channels down.
// - Power-down pin low powers down all channels and the reference.
// - Reference pin goes high impedance while the reference is down.
// - Transparent mode resumes operation once the power-down pin rises.
// - Sample/hold stays fully down after release until any rising edge.
// - Rising edges closer than the idle timeout update the channel code.
// - After a sample/hold wake, an output is high-Z until updated.
// - Idle timeout runs from the latest rising edge, nominally sixty ms.
// - Transparent idle low gives zero-scale, idle high gives full-scale.
// - Edge pairs beyond the timeout are ignored; sample/hold keeps the code.
// - On each rising edge within the timeout the code is 2^N times high time over period.
module pdc_power_ctrl #(
	parameter            RES      = 12,
	parameter            CNTW     = 22,
	parameter [CNTW-1:0] IDLE_CYC = `PDC_IDLE_TIMEOUT_MS * `PDC_CLK_KHZ
) (
	// Clock and reset
	input  wire              i_core_clk,
	input  wire              i_rst_b,
	// Pins
	input  wire [3:0]        i_pwm,
	input  wire              i_power_down_n,
	input  wire              i_idle_mode_select,
	input  wire              i_reference_select,
	// Converter control
	output wire [4*RES-1:0]  o_code,
	output wire [3:0]        o_chan_pd,
	output wire [3:0]        o_analog_output_x_oe,
	output wire              o_ref_pd,
	output wire              o_ref_oe,
	output wire              o_ext_ref,
	// AXI4-Lite write
	input  wire [7:0]        i_s_axi_awaddr,
	input  wire              i_s_axi_awvalid,
	output wire              o_s_axi_awready,
	input  wire [31:0]       i_s_axi_wdata,
	input  wire [3:0]        i_s_axi_wstrb,
	input  wire              i_s_axi_wvalid,
	output wire              o_s_axi_wready,
	output reg  [1:0]        o_s_axi_bresp,
	output reg               o_s_axi_bvalid,
	input  wire              i_s_axi_bready,
	// AXI4-Lite read
	input  wire [7:0]        i_s_axi_araddr,
	input  wire              i_s_axi_arvalid,
	output wire              o_s_axi_arready,
	output reg  [31:0]       o_s_axi_rdata,
	output reg  [1:0]        o_s_axi_rresp,
	output reg               o_s_axi_rvalid,
	input  wire              i_s_axi_rready
);

	// ==========================================================
	// Pin synchronisers: a change counts once stages two and three agree
	reg  [6:0] pin_s1;
	reg  [6:0] pin_s2;
	reg  [6:0] pin_s3;
	reg  [6:0] pin_f;
	reg  [3:0] pwm_d;
	wire [6:0] pin_raw = {i_reference_select, i_idle_mode_select,
	                      i_power_down_n, i_pwm};

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			pin_s1 <= `PDC_PIN_RST;
			pin_s2 <= `PDC_PIN_RST;
			pin_s3 <= `PDC_PIN_RST;
			pin_f  <= `PDC_PIN_RST;
			pwm_d  <= 4'h0;
		end else begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
			pwm_d  <= pin_f[3:0];
		end
	end

	wire [3:0] pwm_lvl  = pin_f[3:0];
	wire [3:0] rise     = pwm_lvl & ~pwm_d;
	wire [3:0] fall     = ~pwm_lvl & pwm_d;
	wire       idle_sel = pin_f[`PDC_PIN_IDLE_SEL];
	wire       ref_sel  = pin_f[`PDC_PIN_REF_SEL];

	// ==========================================================
	// Global power-down
	reg        soft_pd;
	reg        asleep;
	wire       pd_req = ~pin_f[`PDC_PIN_PD_N] | soft_pd;

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			asleep <= 1'b0;
		end else if (pd_req) begin
			asleep <= 1'b1;
		end else if (asleep && (!idle_sel || (|rise))) begin
			asleep <= 1'b0;
		end
	end

	// ==========================================================
	// Channels
	wire [3:0] chan_off;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_chan
			reg  [CNTW-1:0]     per_cnt;
			reg  [CNTW-1:0]     high_cnt;
			reg                 have_prev;
			reg                 off;
			reg  [RES-1:0]      code;
			wire                idle = (per_cnt >= IDLE_CYC);
			wire [CNTW+RES-1:0] num  = {high_cnt, {RES{1'b0}}};
			wire [CNTW+RES-1:0] den  = {{RES{1'b0}}, per_cnt};
			wire [CNTW+RES-1:0] quo  = num / den;
			wire                sat  = |quo[CNTW+RES-1:RES];

			always @(posedge i_core_clk) begin
				if (!i_rst_b) begin
					per_cnt   <= {CNTW{1'b0}};
					high_cnt  <= {CNTW{1'b0}};
					have_prev <= 1'b0;
					off       <= 1'b1;
					code      <= {RES{1'b0}};
				end else begin
					// Timer saturates at the timeout so it never wraps
					if (rise[g]) begin
						per_cnt <= {{(CNTW-1){1'b0}}, 1'b1};
					end else if (!idle) begin
						per_cnt <= per_cnt + 1'b1;
					end
					if (fall[g]) begin
						high_cnt <= per_cnt;
					end
					if (asleep) begin
						// First edge after wake only arms the pair
						have_prev <= rise[g] & ~pd_req;
						off       <= 1'b1;
					end else if (rise[g]) begin
						have_prev <= 1'b1;
						if (have_prev && !idle) begin
							code <= sat ? {RES{1'b1}} : quo[RES-1:0];
							off  <= 1'b0;
						end
					end else if (idle) begin
						have_prev <= 1'b0;
						if (!idle_sel) begin
							code <= pwm_lvl[g] ? {RES{1'b1}} : {RES{1'b0}};
						end else if (!pwm_lvl[g]) begin
							off <= 1'b1;
						end
					end
				end
			end

			assign chan_off[g]             = off;
			assign o_code[g*RES +: RES]    = code;
		end
	endgenerate

	// Transparent mode never powers a channel down on idle
	wire [3:0] idle_off = {4{idle_sel}} & chan_off;
	assign o_chan_pd            = {4{asleep}} | idle_off;
	assign o_analog_output_x_oe = ~o_chan_pd;
	assign o_ext_ref            = ref_sel;
	assign o_ref_pd             = ref_sel | asleep | (&o_chan_pd);
	assign o_ref_oe             = ~o_ref_pd;

	// ==========================================================
	// AXI4-Lite slave: one write and one read in flight
	wire wr_go = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
	wire rd_go = i_s_axi_arvalid & ~o_s_axi_rvalid;

	assign o_s_axi_awready = wr_go;
	assign o_s_axi_wready  = wr_go;
	assign o_s_axi_arready = ~o_s_axi_rvalid;

	wire [31:0] status = {24'h0, idle_sel, asleep, ref_sel, o_ref_pd,
	                      o_chan_pd};

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			soft_pd        <= `PDC_CTRL_RST;
			o_s_axi_bvalid <= 1'b0;
			o_s_axi_bresp  <= `PDC_RESP_OKAY;
		end else begin
			if (wr_go) begin
				o_s_axi_bvalid <= 1'b1;
				if (i_s_axi_awaddr == `PDC_OFS_CTRL) begin
					o_s_axi_bresp <= `PDC_RESP_OKAY;
					if (i_s_axi_wstrb[0]) begin
						soft_pd <= i_s_axi_wdata[`PDC_CTRL_SOFT_PD];
					end
				end else if (i_s_axi_awaddr == `PDC_OFS_STATUS ||
				             i_s_axi_awaddr == `PDC_OFS_CODE0 ||
				             i_s_axi_awaddr == `PDC_OFS_CODE1 ||
				             i_s_axi_awaddr == `PDC_OFS_CODE2 ||
				             i_s_axi_awaddr == `PDC_OFS_CODE3) begin
					o_s_axi_bresp <= `PDC_RESP_OKAY;
				end else begin
					o_s_axi_bresp <= `PDC_RESP_SLVERR;
				end
			end else if (i_s_axi_bready) begin
				o_s_axi_bvalid <= 1'b0;
			end
		end
	end

	always @(posedge i_core_clk) begin
		if (!i_rst_b) begin
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata  <= 32'h0;
			o_s_axi_rresp  <= `PDC_RESP_OKAY;
		end else if (rd_go) begin
			o_s_axi_rvalid <= 1'b1;
			o_s_axi_rresp  <= `PDC_RESP_OKAY;
			case (i_s_axi_araddr)
			`PDC_OFS_CTRL: begin
				o_s_axi_rdata <= {31'h0, soft_pd};
			end
			`PDC_OFS_STATUS: begin
				o_s_axi_rdata <= status;
			end
			`PDC_OFS_CODE0: begin
				o_s_axi_rdata <= {{(32-RES){1'b0}}, g_chan[0].code};
			end
			`PDC_OFS_CODE1: begin
				o_s_axi_rdata <= {{(32-RES){1'b0}}, g_chan[1].code};
			end
			`PDC_OFS_CODE2: begin
				o_s_axi_rdata <= {{(32-RES){1'b0}}, g_chan[2].code};
			end
			`PDC_OFS_CODE3: begin
				o_s_axi_rdata <= {{(32-RES){1'b0}}, g_chan[3].code};
			end
			default: begin
				o_s_axi_rdata <= 32'h0;
				o_s_axi_rresp <= `PDC_RESP_SLVERR;
			end
			endcase
		end else if (i_s_axi_rready) begin
			o_s_axi_rvalid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ==== logic/pdc_defs.vh ====
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// ==========================================================
// Timing
`define PDC_CLK_KHZ          40000
`define PDC_IDLE_TIMEOUT_MS  60

// ==========================================================
// Register byte offsets
`define PDC_OFS_CTRL         8'h00
`define PDC_OFS_STATUS       8'h04
`define PDC_OFS_CODE0        8'h10
`define PDC_OFS_CODE1        8'h14
`define PDC_OFS_CODE2        8'h18
`define PDC_OFS_CODE3        8'h1c

// ==========================================================
// Control fields
`define PDC_CTRL_SOFT_PD     0
`define PDC_CTRL_RST         1'h0

// ==========================================================
// Status fields
`define PDC_ST_CHAN_PD_LSB   0
`define PDC_ST_REF_PD        4
`define PDC_ST_EXT_REF       5
`define PDC_ST_ASLEEP        6
`define PDC_ST_IDLE_SEL      7

// ==========================================================
// Pin vector layout and reset level of the filtered pins
`define PDC_PIN_PD_N         4
`define PDC_PIN_IDLE_SEL     5
`define PDC_PIN_REF_SEL      6
`define PDC_PIN_RST          7'h10

// ==========================================================
// Bus responses
`define PDC_RESP_OKAY        2'h0
`define PDC_RESP_SLVERR      2'h2

`endif

// ==== dv/pdc_power_ctrl_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Pin-level power checks
module pdc_power_ctrl_chk #(
	parameter RES = 12
) (
	input wire             i_core_clk,
	input wire             i_rst_b,
	input wire [3:0]       i_pwm,
	input wire             i_power_down_n,
	input wire             i_idle_mode_select,
	input wire             i_reference_select,
	input wire [4*RES-1:0] o_code,
	input wire [3:0]       o_chan_pd,
	input wire [3:0]       o_analog_output_x_oe,
	input wire             o_ref_pd,
	input wire             o_ref_oe,
	input wire             o_ext_ref
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	// Pins cross a sync filter of up to five edges, hence the settle windows
	ref_mode_a: assert property (
		$stable(i_reference_select) [*6] |-> o_ext_ref == i_reference_select)
		else $error("reference mode wrong");
	ext_off_a: assert property (o_ext_ref |-> o_ref_pd)
		else $error("reference on in external mode");
	all_down_a: assert property (&o_chan_pd |-> o_ref_pd)
		else $error("reference on, channels down");
	pin_down_a: assert property (
		!i_power_down_n [*7] |-> &o_chan_pd && o_ref_pd)
		else $error("power-down pin ignored");
	ref_hiz_a: assert property (o_ref_oe == !o_ref_pd)
		else $error("reference pin drive wrong");
	out_hiz_a: assert property (o_analog_output_x_oe == ~o_chan_pd)
		else $error("output drive wrong");
	trans_run_a: assert property (
		(!i_idle_mode_select && i_power_down_n) [*8] |-> o_chan_pd == 4'h0)
		else $error("channel down in transparent mode");
	code_hold_a: assert property (
		(i_idle_mode_select && $stable(i_pwm)) [*8] |=> $stable(o_code))
		else $error("code moved without an edge");
endmodule
bind pdc_power_ctrl pdc_power_ctrl_chk #(.RES(RES)) u_chk (
	.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_pwm(i_pwm),
	.i_power_down_n(i_power_down_n), .o_code(o_code),
	.i_idle_mode_select(i_idle_mode_select),
	.i_reference_select(i_reference_select), .o_chan_pd(o_chan_pd),
	.o_analog_output_x_oe(o_analog_output_x_oe), .o_ref_pd(o_ref_pd),
	.o_ref_oe(o_ref_oe), .o_ext_ref(o_ext_ref));
`default_nettype wire

// ==== dv/pdc_pwm_src.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// PWM source on the far side of the four inputs
module pdc_pwm_src (
	input  wire logic        i_clk,
	input  wire logic [3:0]  i_en,
	input  wire logic [3:0]  i_lvl,
	input  wire logic [31:0] i_high,
	output var  logic [3:0]  o_pwm
);
	// One shared 64-cycle period keeps every expected code exact
	logic [5:0] cnt = 6'h00;
	always_ff @(posedge i_clk) begin
		cnt <= cnt + 6'h01;
		for (int g = 0; g < 4; g++) begin
			o_pwm[g] <= i_en[g] ? (cnt < i_high[g*8+:8]) : i_lvl[g];
		end
	end
endmodule
`default_nettype wire

// ==== dv/pwm_dac_power_down_control_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========
// Directed bench
module pwm_dac_power_down_control_tb;
	logic        clk = 0, rst_b = 0, pd_n = 1, idl = 0, rsel = 0;
	logic        awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic        awr, wrd, bv, arr, rv, rpd, roe, ext;
	logic [3:0]  en = 0, lvl = 0, pwm, chpd, oe;
	logic [3:0]  ws = 4'hf;
	logic [7:0]  awa = 0, ara = 0;
	logic [31:0] hi = 32'h08302010, wd = 0, rd;
	logic [1:0]  bresp, rresp;
	logic [47:0] code;
	int          mismatches = 0, checks_done = 0;
	always #12.5 clk = ~clk;
	pdc_pwm_src u_pdc_pwm_src (.i_clk(clk), .i_en(en), .i_lvl(lvl),
		.i_high(hi), .o_pwm(pwm));
	// Short idle timeout keeps the run brief; waits are scaled to it
	pdc_power_ctrl #(.IDLE_CYC(22'd200)) u_pdc_power_ctrl (
		.i_core_clk(clk), .i_rst_b(rst_b), .i_pwm(pwm),
		.i_power_down_n(pd_n), .i_idle_mode_select(idl),
		.i_reference_select(rsel), .o_code(code), .o_chan_pd(chpd),
		.o_analog_output_x_oe(oe), .o_ref_pd(rpd), .o_ref_oe(roe),
		.o_ext_ref(ext), .i_s_axi_awaddr(awa), .i_s_axi_awvalid(awv),
		.o_s_axi_awready(awr), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
		.i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bv), .i_s_axi_bready(br), .i_s_axi_araddr(ara),
		.i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .o_s_axi_rdata(rd),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rv), .i_s_axi_rready(rr));
	task automatic chk(input string n, input logic [47:0] s, e);
		checks_done++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic stop_test;
		if (mismatches == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge clk);
		{awa, wd, awv, wv, br} <= {a, d, 3'b111};
		do @(posedge clk); while (!(awr && wrd));
		{awv, wv} <= 2'b00;
		while (!bv) @(posedge clk);
		br <= 0;
		chk("bresp", bresp, er);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge clk);
		{ara, arv, rr} <= {a, 2'b11};
		do @(posedge clk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge clk);
		rr <= 0;
		chk("rdata", rd, ed);
		chk("rresp", rresp, er);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1;
		en <= 4'hf;
		repeat (200) @(posedge clk);
		chk("code", code, 48'h200c00800400);
		chk("pd", chpd, 4'h0);
		lvl <= 4'ha;
		en <= 4'h0;
		repeat (300) @(posedge clk);
		chk("idle", code, 48'hfff000fff000);
		rsel <= 1;
		repeat (10) @(posedge clk);
		chk("ext", {ext, rpd, roe}, 3'b110);
		rsel <= 0;
		pd_n <= 0;
		repeat (10) @(posedge clk);
		chk("pin", {ext, chpd, rpd, roe}, 7'h3e);
		pd_n <= 1;
		repeat (10) @(posedge clk);
		chk("wake", {chpd, rpd, roe}, 6'h01);
		{idl, en, lvl} <= 9'h1f0;
		repeat (200) @(posedge clk);
		chk("sh", code, 48'h200c00800400);
		en <= 4'he;
		repeat (300) @(posedge clk);
		chk("ch0", {chpd, rpd}, 5'h02);
		chk("oe", oe, 4'he);
		rd_reg(8'h04, 32'h81, 2'h0);
		rd_reg(8'h10, 32'd1024, 2'h0);
		en <= 4'h0;
		repeat (300) @(posedge clk);
		chk("all", {chpd, rpd}, 5'h1f);
		pd_n <= 0;
		repeat (10) @(posedge clk);
		pd_n <= 1;
		repeat (300) @(posedge clk);
		chk("asleep", {chpd, rpd}, 5'h1f);
		hi[23:16] <= 8'd40;
		en <= 4'h4;
		repeat (200) @(posedge clk);
		chk("ch2", {chpd, rpd}, 5'h16);
		chk("oe2", oe, 4'h4);
		wr(8'h00, 1, 2'h0);
		repeat (10) @(posedge clk);
		rd_reg(8'h04, 32'hdf, 2'h0);
		rd_reg(8'h00, 1, 2'h0);
		wr(8'h00, 0, 2'h0);
		// A write with its low strobe off must leave the control bit alone
		ws <= 4'h0;
		wr(8'h00, 1, 2'h0);
		rd_reg(8'h00, 0, 2'h0);
		ws <= 4'hf;
		wr(8'h04, 0, 2'h0);
		wr(8'h20, 1, 2'h2);
		rd_reg(8'h20, 0, 2'h2);
		rd_reg(8'h18, 32'd2560, 2'h0);
		stop_test;
	end
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		stop_test;
	end
endmodule
`default_nettype wire
